// ==== hw/can_bus_failure_manager.sv ====
// CAN bus failure manager top
`default_nettype none
module can_bus_failure_manager (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst_n,
  // Mode
  input  wire bfm_pkg::op_mode_t  mode,
  // Protocol controller side
  input  wire logic               txd,
  output logic                    rxd,
  // Bus comparators
  input  wire logic               diff_rx,
  input  wire logic               high_rx,
  input  wire logic               low_rx,
  // Failure detectors and thermal sensor
  input  wire logic [8:0]         fail_raw,
  input  wire logic               over_temp,
  // Bus drivers and terminations
  output logic                    drv_high_en,
  output logic                    drv_low_en,
  output logic                    term_high_en,
  output logic                    term_low_en,
  // Serial status
  input  wire logic               select_low_pin,
  output logic                    status_word_bit,
  output logic [15:0]             diag_word,
  // Regulator loop
  input  wire logic               supply_low_threshold,
  input  wire logic               supply_nominal,
  output logic                    reg_en,
  output logic                    supply_reset
);
  import bfm_pkg::*;

  // ==========================================
  // Timebase
  tick_if tb ();
  logic [15:0] tb_cnt_q;
  logic        tick_q;
  assign tb.tick = tick_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tb_cnt_q <= 16'h0000;
      tick_q   <= 1'b0;
    end else if (tb_cnt_q == 16'(TICK_CYC - 1)) begin
      tb_cnt_q <= 16'h0000;
      tick_q   <= 1'b1;
    end else begin
      tb_cnt_q <= tb_cnt_q + 16'h0001;
      tick_q   <= 1'b0;
    end
  end

  // ==========================================
  // Failure filters
  logic [8:0] fail_f;
  genvar g;
  generate
    for (g = 0; g < NFAIL; g++) begin : g_filt
      delay_filter u_filt (
        .clock     (clock),
        .rst_n     (rst_n),
        .tb        (tb),
        .raw       (fail_raw[g]),
        .on_ticks  (ENTRY_TICKS),
        .off_ticks (EXIT_TICKS),
        .filtered  (fail_f[g])
      );
    end
  endgenerate

  // Faulty wire: high side for 3, 5, 7; low side for 6, 6a unless the high side is bad
  logic high_bad;
  logic low_bad;
  assign high_bad = fail_f[F3] | fail_f[F5] | fail_f[F7];
  assign low_bad  = (fail_f[F6] | fail_f[F6A]) & ~high_bad;

  // ==========================================
  // Dominant transmit timeout
  logic [7:0] txd_cnt_q;
  logic       txd_block_q;
  logic       txd_dom;
  assign txd_dom = ~txd;

  always_ff @(posedge clock) begin
    if (!rst_n || !txd_dom) begin
      txd_cnt_q   <= 8'h00;
      txd_block_q <= 1'b0;
    end else if (tb.tick && !txd_block_q) begin
      if (txd_cnt_q + 8'h01 >= TXD_TICKS) begin
        txd_block_q <= 1'b1;
      end else begin
        txd_cnt_q <= txd_cnt_q + 8'h01;
      end
    end
  end

  // ==========================================
  // Driver and receive path
  logic tx_allowed;
  logic rx_allowed;
  rx_sel_t rx_sel;
  assign tx_allowed = (mode == MODE_NORMAL) & ~txd_block_q & ~over_temp;
  assign rx_allowed = (mode == MODE_NORMAL) | (mode == MODE_RX_ONLY);

  always_comb begin
    if (high_bad) begin
      rx_sel = RX_LOW;
    end else if (low_bad) begin
      rx_sel = RX_HIGH;
    end else begin
      rx_sel = RX_DIFF;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rxd          <= 1'b1;
      drv_high_en  <= 1'b0;
      drv_low_en   <= 1'b0;
      term_high_en <= 1'b1;
      term_low_en  <= 1'b1;
    end else begin
      unique case (rx_sel)
        RX_HIGH: rxd <= rx_allowed ? high_rx : 1'b1;
        RX_LOW:  rxd <= rx_allowed ? low_rx : 1'b1;
        default: rxd <= rx_allowed ? diff_rx : 1'b1;
      endcase
      drv_high_en  <= tx_allowed & txd_dom & ~high_bad;
      drv_low_en   <= tx_allowed & txd_dom & ~low_bad;
      term_high_en <= ~high_bad;
      term_low_en  <= ~low_bad;
    end
  end

  // ==========================================
  // Diagnosis flags
  logic [15:0] live;
  logic [15:0] diag_q;
  logic        tx_start;
  logic        txd_prev_q;
  logic        sel_prev_q;
  logic        sum_q;

  always_comb begin
    live              = 16'h0000;
    live[BIT_F2_4]    = fail_f[F2] | fail_f[F4];
    live[BIT_F1_3A]   = fail_f[F1] | fail_f[F3A];
    live[BIT_F6]      = fail_f[F6];
    live[BIT_F6A]     = fail_f[F6A];
    live[BIT_F5_7]    = fail_f[F5] | fail_f[F7];
    live[BIT_F3]      = fail_f[F3];
    live[BIT_THERMAL] = over_temp;
  end

  assign tx_start = txd_prev_q & ~txd;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      txd_prev_q <= 1'b1;
      sel_prev_q <= 1'b1;
    end else begin
      txd_prev_q <= txd;
      sel_prev_q <= select_low_pin;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      diag_q <= DIAG_RESET;
    end else if (tx_start) begin
      diag_q <= live;
    end else begin
      diag_q <= diag_q | live;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sum_q <= 1'b0;
    end else if (|fail_f) begin
      sum_q <= 1'b1; // Set wins over clear
    end else if (select_low_pin && !sel_prev_q) begin
      sum_q <= 1'b0;
    end
  end

  always_comb begin
    diag_word              = diag_q;
    diag_word[BIT_SUMMARY] = sum_q;
  end
  assign status_word_bit = ~select_low_pin & sum_q;

  // ==========================================
  // Regulator loop in cyclic wake
  reg_state_t  rs_q;
  logic [16:0] rcnt_q;
  logic [8:0]  low_cnt_q;
  logic        cyc;
  assign cyc = (mode == MODE_CYCLIC);

  always_ff @(posedge clock) begin
    if (!rst_n || !cyc) begin
      rs_q   <= REG_IDLE;
      rcnt_q <= 17'h00000;
    end else begin
      unique case (rs_q)
        REG_IDLE: if (supply_low_threshold) begin
          rs_q <= REG_CHARGE;
        end
        REG_CHARGE: if (!supply_low_threshold) begin
          rs_q   <= REG_EXTRA;
          rcnt_q <= 17'h00000;
        end
        REG_EXTRA: if (rcnt_q == 17'(CHARGE_CYC - 1)) begin
          rs_q <= REG_TOP;
        end else begin
          rcnt_q <= rcnt_q + 17'h00001;
        end
        REG_TOP: if (supply_nominal) begin
          rs_q <= REG_IDLE;
        end
      endcase
    end
  end
  assign reg_en = !cyc | (rs_q != REG_IDLE);

  always_ff @(posedge clock) begin
    if (!rst_n || !cyc || !supply_low_threshold) begin
      low_cnt_q    <= 9'h000;
      supply_reset <= 1'b0;
    end else if (low_cnt_q == 9'(LOW_LIMIT_CYC)) begin
      supply_reset <= 1'b1;
    end else begin
      low_cnt_q <= low_cnt_q + 9'h001;
    end
  end
endmodule
`default_nettype wire

// ==== hw/bfm_pkg.sv ====
// Constants and types for the CAN bus failure manager
// Contract
// - Receive-only mode keeps delivering bus levels but never drives the bus.
// - On a wiring failure switch from differential to single-wire on the good line.
// - Enter single-wire mode only after the failure persists for the entry delay.
// - Return to differential only after a separate exit delay once failure clears.
// - Failures 3, 5, 6, 6a, 7 switch off termination and driver of the faulty wire; the code leaves the low wire on for 6, 6a while 3, 5 or 7 is present.
// - When a wire is disabled, receive from the unaffected single-ended comparator.
// - Failures 1, 2, 3a, 4 keep the differential receiver selected.
// - Report failures: bit13 2/4, 12 1/3a, 11 6, 10 6a, 9 5/7, 8 3.
// - Failure flags hold until the next transmission begins, then re-evaluate.
// - Summary failure bit 0 is visible on data out while select is low.
// - A select low-to-high transition clears summary bit 0.
// - Transmit dominant beyond a timeout disables both bus drivers.
// - Over-temperature shuts off drivers while reception continues.
// - Transceiver thermal shutdown is reported at diagnosis bit 15.
// - In cyclic wake with switches off, enable regulator when supply drops below threshold.
// - After supply returns to threshold keep charging an extra 1 ms.
// - At nominal level turn the regulator off; the loop repeats.
// - Supply below threshold for more than 3 us raises a reset.
// - Receive-only mode, chosen by mode setting, disables transmit, keeps receive.
`default_nettype none
package bfm_pkg;
  // Clock and time
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned CHARGE_US     = 1000;
  localparam int unsigned LOW_LIMIT_NS  = 3000;
  localparam int unsigned CHARGE_CYC    = CHARGE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LOW_LIMIT_CYC = LOW_LIMIT_NS / (1_000_000_000 / CLK_HZ);
  // Oscillator timebase: 125 kHz / 64 tick, 512 us
  localparam int unsigned TICK_US       = 512;
  localparam int unsigned TICK_CYC      = TICK_US * (CLK_HZ / 1_000_000);
  // Filter terminal counts in timebase ticks
  localparam logic [7:0]  ENTRY_TICKS   = 8'h02;
  localparam logic [7:0]  EXIT_TICKS    = 8'h04;
  localparam logic [7:0]  TXD_TICKS     = 8'h03;
  // Diagnosis word bit positions
  localparam int unsigned BIT_SUMMARY   = 0;
  localparam int unsigned BIT_F3        = 8;
  localparam int unsigned BIT_F5_7      = 9;
  localparam int unsigned BIT_F6A       = 10;
  localparam int unsigned BIT_F6        = 11;
  localparam int unsigned BIT_F1_3A     = 12;
  localparam int unsigned BIT_F2_4      = 13;
  localparam int unsigned BIT_THERMAL   = 15;
  localparam logic [15:0] DIAG_RESET    = 16'h0000;
  // Failure input index
  localparam int unsigned NFAIL = 9;
  localparam int unsigned F1 = 0;
  localparam int unsigned F2 = 1;
  localparam int unsigned F3 = 2;
  localparam int unsigned F3A = 3;
  localparam int unsigned F4 = 4;
  localparam int unsigned F5 = 5;
  localparam int unsigned F6 = 6;
  localparam int unsigned F6A = 7;
  localparam int unsigned F7 = 8;
  // Operating modes
  typedef enum logic [1:0] {
    MODE_NORMAL  = 2'h0,
    MODE_RX_ONLY = 2'h1,
    MODE_STANDBY = 2'h2,
    MODE_CYCLIC  = 2'h3
  } op_mode_t;
  // Receive source
  typedef enum logic [1:0] {
    RX_DIFF = 2'h0,
    RX_HIGH = 2'h1,
    RX_LOW  = 2'h2
  } rx_sel_t;
  // Regulator loop states
  typedef enum logic [3:0] {
    REG_IDLE   = 4'h1,
    REG_CHARGE = 4'h2,
    REG_EXTRA  = 4'h4,
    REG_TOP    = 4'h8
  } reg_state_t;
endpackage
`default_nettype wire

// ==== hw/tick_if.sv ====
// Timebase tick shared between failure manager and filters
`default_nettype none
interface tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface
`default_nettype wire

// ==== hw/delay_filter.sv ====
// Persistence filter counted in timebase ticks
`default_nettype none
module delay_filter
  import bfm_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Timebase
  tick_if.dst             tb,
  // Filter
  input  wire logic       raw,
  input  wire logic [7:0] on_ticks,
  input  wire logic [7:0] off_ticks,
  output logic            filtered
);
  logic [7:0] cnt_q;
  logic       filt_q;

  assign filtered = filt_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_q  <= 8'h00;
      filt_q <= 1'b0;
    end else if (raw == filt_q) begin
      cnt_q <= 8'h00;
    end else if (tb.tick) begin
      if (cnt_q + 8'h01 >= (filt_q ? off_ticks : on_ticks)) begin
        filt_q <= raw;
        cnt_q  <= 8'h00;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/bus_partner.sv ====
// Model of the far nodes and the two-wire bus
`default_nettype none
module bus_partner (
  // Far nodes and wiring
  input  wire logic remote,
  input  wire logic high_short,
  // Device drivers
  input  wire logic drv_high_en,
  input  wire logic drv_low_en,
  // Comparator outputs, low is dominant
  output logic      diff_rx,
  output logic      high_rx,
  output logic      low_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic level;
  // Wired-and: any active driver pulls the bus dominant
  assign level = remote & ~drv_high_en & ~drv_low_en;
  // Shorted high wire sticks recessive and corrupts the differential path
  assign high_rx = high_short | level;
  assign diff_rx = high_short ? ~level : level;
  assign low_rx = level;
endmodule
`default_nettype wire

// ==== verif/bfm_checker.sv ====
// Port assertions for the bus failure manager
`default_nettype none
module bfm_checker (
  // Clock and reset
  input wire logic              clock,
  input wire logic              rst_n,
  // Watched ports
  input wire bfm_pkg::op_mode_t mode,
  input wire logic              rxd,
  input wire logic              low_rx,
  input wire logic              over_temp,
  input wire logic              drv_high_en,
  input wire logic              drv_low_en,
  input wire logic              term_high_en,
  input wire logic              select_low_pin,
  input wire logic              status_word_bit,
  input wire logic [15:0]       diag_word,
  input wire logic              supply_low_threshold,
  input wire logic              reg_en,
  input wire logic              supply_reset
);
  import bfm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Consecutive low-supply cycles in cyclic wake
  logic [8:0] low_q;
  always_ff @(posedge clock) begin
    if (!rst_n || !supply_low_threshold || mode != MODE_CYCLIC) begin
      low_q <= 9'h000;
    end else if (low_q != 9'h1ff) begin
      low_q <= low_q + 9'h001;
    end
  end
  chk_rx_only_quiet: assert property (mode == MODE_RX_ONLY && $past(mode) == MODE_RX_ONLY
    |-> !drv_high_en && !drv_low_en) else $error("driver on in receive-only mode");
  chk_status_out: assert property (status_word_bit == (!select_low_pin && diag_word[0]))
    else $error("status bit wrong");
  chk_diag_spare: assert property (diag_word[7:1] == 7'h00 && !diag_word[14])
    else $error("spare diagnosis bit set");
  chk_heat_drv: assert property (over_temp |=> !drv_high_en && !drv_low_en)
    else $error("driver on while hot");
  chk_reg_wake: assert property (mode == MODE_CYCLIC && $past(mode) == MODE_CYCLIC
    && supply_low_threshold |-> ##[0:2] reg_en) else $error("regulator not enabled");
  chk_low_reset: assert property (low_q == 9'h136 |-> supply_reset)
    else $error("no reset after long low supply");
  chk_rx_idle: assert property (mode[1] && $past(mode[1]) |-> rxd)
    else $error("receive active in low power mode");
  chk_wire_off: assert property (!term_high_en && $past(!term_high_en) |-> !drv_high_en)
    else $error("disabled wire driven");
  chk_single_rx: assert property (!term_high_en && $past(!term_high_en) && mode == MODE_NORMAL
    && $past(mode) == MODE_NORMAL |-> rxd == $past(low_rx)) else $error("rxd source wrong");
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the bus failure manager
`default_nettype none
module tb_top;
  import bfm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [23:0] msk;
    logic [23:0] exp;
  } note_t;
  logic        clock, rst_n, txd, over_temp, remote, high_short, select_low_pin;
  logic        supply_low_threshold, supply_nominal, rxd, diff_rx, high_rx, low_rx;
  logic        drv_high_en, drv_low_en, term_high_en, term_low_en, status_word_bit;
  logic        reg_en, supply_reset, ex;
  logic [8:0]  fail_raw;
  logic [15:0] diag_word;
  logic [31:0] rnd = 32'h04b4fb80;
  op_mode_t    mode;
  note_t       notes[$];
  note_t       n;
  int          fail_count, num_checks, cycles, k;
  wire logic [23:0] obs = {diag_word, rxd, drv_high_en, drv_low_en, term_high_en,
                           term_low_en, status_word_bit, reg_en, supply_reset};
  can_bus_failure_manager dut (.*);
  bus_partner partner (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clock);
  endtask
  // Note an expectation; the monitor compares at the next edge
  task automatic chk(input logic [23:0] msk, input logic [23:0] exp);
    @(negedge clock);
    notes.push_back('{msk, exp});
    @(posedge clock);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 120000) begin
      fail_count++;
      results();
    end
    if (notes.size() != 0) begin
      n = notes.pop_front();
      num_checks++;
      if ((obs & n.msk) !== n.exp) begin
        fail_count++;
        $display("mismatch outputs expected %h seen %h", n.exp, obs & n.msk);
      end
    end
  end
  // ======
  // Main sequence
  initial begin
    rst_n = 1'b0;
    mode = MODE_NORMAL;
    txd = 1'b1;
    over_temp = 1'b0;
    fail_raw = 9'h000;
    remote = 1'b1;
    high_short = 1'b0;
    select_low_pin = 1'b1;
    supply_low_threshold = 1'b0;
    supply_nominal = 1'b0;
    wait_cyc(6);
    rst_n <= 1'b1;
    chk(24'hffffff, 24'h00009a);
    for (k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      mode <= op_mode_t'({1'b0, rnd[2]});
      txd <= rnd[0];
      remote <= rnd[1];
      ex = rnd[2] | rnd[0];
      wait_cyc(4);
      chk(24'h0000e0, {16'h0000, rnd[1] & ex, ~ex, ~ex, 5'h00});
    end
    mode <= MODE_NORMAL;
    txd <= 1'b0;
    remote <= 1'b0;
    over_temp <= 1'b1;
    wait_cyc(4);
    chk(24'h8000e0, 24'h800000);
    over_temp <= 1'b0;
    txd <= 1'b1;
    remote <= 1'b1;
    wait_cyc(4);
    chk(24'h800000, 24'h800000);
    txd <= 1'b0;
    wait_cyc(4);
    chk(24'h800060, 24'h000060);
    txd <= 1'b1;
    mode <= MODE_CYCLIC;
    wait_cyc(4);
    chk(24'h000083, 24'h000080);
    supply_low_threshold <= 1'b1;
    wait_cyc(3);
    chk(24'h000003, 24'h000002);
    wait_cyc(320);
    chk(24'h000003, 24'h000003);
    supply_low_threshold <= 1'b0;
    wait_cyc(3);
    chk(24'h000003, 24'h000002);
    mode <= MODE_NORMAL;
    fail_raw[F3] <= 1'b1;
    high_short <= 1'b1;
    wait_cyc(1000);
    chk(24'h000010, 24'h000010);
    for (k = 0; k < 110000 && term_high_en !== 1'b0; k++) @(posedge clock);
    wait_cyc(2);
    chk(24'h010158, 24'h010108);
    select_low_pin <= 1'b0;
    txd <= 1'b0;
    wait_cyc(4);
    chk(24'h0000e4, 24'h000024);
    select_low_pin <= 1'b1;
    txd <= 1'b1;
    wait_cyc(3);
    chk(24'h010100, 24'h010100);
    results();
  end
endmodule
bind can_bus_failure_manager bfm_checker chk_i (.*);
`default_nettype wire
